// ==== gpio_pkg.sv ====
// Purpose: Shared constants and types for the five-port general purpose I/O block
// Assumes: Byte-wide register port, one core clock
// Notes:   Offsets are byte addresses on the register port
package gpio_pkg;
  localparam int          NUM_PORTS      = 5;
  localparam int          PORT_WIDTH     = 8;
  localparam int          NUM_VECTORS    = 5;
  localparam int          ADDR_WIDTH     = 8;
  localparam logic [7:0]  PORT_BASE_ADDR = 8'h26;
  localparam logic [7:0]  PORT_STRIDE    = 8'h03;
  localparam logic [7:0]  DATA_OFS       = 8'h00;
  localparam logic [7:0]  DIR_OFS        = 8'h01;
  localparam logic [7:0]  OPT_OFS        = 8'h02;
  localparam logic [7:0]  EIEN_BASE_ADDR = 8'h40;
  localparam logic [7:0]  EDGE_CTRL_ADDR = 8'h45;
  localparam logic [7:0]  PEND_ADDR      = 8'h46;
  localparam logic [7:0]  PKG_CFG_ADDR   = 8'h47;
  localparam logic [7:0]  REG_RESET      = 8'h00;
  localparam logic [7:0]  EDGE_RESET     = 8'h00;
  localparam logic [7:0]  PKG_RESET      = 8'h00;
  localparam logic [7:0]  UNMAP_READ     = 8'h00;
  localparam int          SYNC_STAGES    = 2;
  // Unbonded pins of the small package, one mask per port A..E
  localparam logic [39:0] UNBONDED_MASK  = 40'h70_E0_00_FF_00;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } gp_bus_req_t;

  typedef struct packed {
    logic [7:0] oe;
    logic [7:0] out;
    logic [7:0] pull_up;
  } gp_pad_drive_t;
endpackage : gpio_pkg

// ==== gpio_ports.sv ====
// Purpose: Five 8-bit general purpose I/O ports with external interrupt logic
// Assumes: Pins and peripheral signals are synchronous to CLK
// Notes:   Each pad output enable is high while the block drives the pin
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// R1: Eight pins per port, bitwise configuration
// R2: Input pin read returns pin level
// R3: Data writes to input pins update latch only
// R4: Input option bit selects pull-up
// R5: Output pin driven from latch, reads latch
// R6: Output option bit selects push-pull
// R7: Zero drives low; one open-drain floats
// R8: Software writes latch before setting direction
// R9: Enable bit lets input edges raise request
// R10: Edge polarity chosen per vector
// R11: Pins of one vector combine
// R12: Vector fetch clears its request latch
// R13: Changing edge bits clears affected requests
// R14: Interrupt needs input, enable, unmasked core
// R15: Peripheral output overrides pin settings
// R16: Input with peripheral output reads peripheral
// R17: Output with peripheral input sees latch
// R18: Software uses floating no-interrupt for peripheral input
// R19: Ports hold in wait/halt; interrupts wake
// R20: Small package unbonded pins pulled-up inputs
// R21: Data registers 8 bits, reset zero
// R22: Unbonded direction/option read zero, data one
// R23: Port registers from 26h, three per port
// R24: Edge inputs pass two-flop synchroniser
module gpio_ports #(
  parameter int NPORTS = gpio_pkg::NUM_PORTS,
  parameter int NVEC   = gpio_pkg::NUM_VECTORS
) (
  // Clock and reset
  input  wire logic                       CLK,
  input  wire logic                       RESET,
  input  wire logic                       CLK_EN,
  // Register port
  input  wire logic [7:0]                 ADDR,
  input  wire logic [7:0]                 WDATA,
  input  wire logic                       WR,
  input  wire logic                       RD,
  output logic [7:0]                      RDATA,
  // Pads
  input  wire logic [NPORTS*8-1:0]        PIN_IN,
  output logic [NPORTS*8-1:0]             PIN_OUT,
  output logic [NPORTS*8-1:0]             PIN_OE,
  output logic [NPORTS*8-1:0]             PIN_PULLUP,
  // Alternate functions
  input  wire logic [NPORTS*8-1:0]        ALT_OUT_EN,
  input  wire logic [NPORTS*8-1:0]        ALT_OUT_VAL,
  input  wire logic [NPORTS*8-1:0]        ALT_IN_EN,
  output logic [NPORTS*8-1:0]             ALT_IN_VAL,
  // Interrupts and core
  input  wire logic                       IRQ_MASKED,
  input  wire logic [NVEC-1:0]            VEC_FETCH,
  output logic [NVEC-1:0]                 EXT_IRQ,
  output logic                            WAKEUP
);
  localparam int NB = NPORTS * 8;

  // The address map and unbonded mask are laid out for five ports only
  if (NPORTS != gpio_pkg::NUM_PORTS || NVEC != gpio_pkg::NUM_VECTORS) begin : g_bad_size
    $error("gpio_ports: only five ports with five vectors are supported");
  end

  logic [NB-1:0]   data_reg;
  logic [NB-1:0]   dir_reg;
  logic [NB-1:0]   opt_reg;
  logic [NB-1:0]   eien_reg;
  logic [7:0]      edge_reg;
  logic            small_pkg_reg;
  logic [NVEC-1:0] pend_reg;
  logic [NB-1:0]   sync1_reg;
  logic [NB-1:0]   sync2_reg;
  logic [NB-1:0]   prev_reg;
  logic [7:0]      rdata_reg;

  logic [NB-1:0]   unbonded;
  logic [NB-1:0]   dir_eff;
  logic [NB-1:0]   opt_eff;
  logic [NB-1:0]   edge_hit;
  logic [NVEC-1:0] vec_event;
  logic [NVEC-1:0] edge_clr;
  logic [7:0]      rd_mux;

  // Port index of an address in the per-port region, or NPORTS if none
  function automatic logic [2:0] port_of(input logic [7:0] a);
    logic [7:0] rel;
    rel = a - gpio_pkg::PORT_BASE_ADDR;
    port_of = 3'(NPORTS);
    if (a >= gpio_pkg::PORT_BASE_ADDR && rel < 8'(NPORTS * 3))
      port_of = 3'(rel / gpio_pkg::PORT_STRIDE);
  endfunction : port_of

  function automatic logic [7:0] field_of(input logic [7:0] a);
    field_of = 8'((a - gpio_pkg::PORT_BASE_ADDR) % gpio_pkg::PORT_STRIDE);
  endfunction : field_of

  assign unbonded = small_pkg_reg ? gpio_pkg::UNBONDED_MASK[NB-1:0] : '0; // R20

  // Unbonded pins forced to input with pull-up
  assign dir_eff = dir_reg & ~unbonded;                     // R20
  assign opt_eff = opt_reg | unbonded;                      // R20

  // Pad drive
  always_comb begin
    for (int i = 0; i < NB; i++) begin                      // R1
      if (ALT_OUT_EN[i] && !unbonded[i]) begin              // R15
        PIN_OUT[i]    = ALT_OUT_VAL[i];
        PIN_OE[i]     = 1'b1;
        PIN_PULLUP[i] = 1'b0;
      end else if (dir_eff[i]) begin                        // R5
        PIN_OUT[i]    = data_reg[i];
        PIN_OE[i]     = !data_reg[i] || opt_eff[i];         // R6 R7
        PIN_PULLUP[i] = 1'b0;
      end else begin                                        // R3
        PIN_OUT[i]    = 1'b0;
        PIN_OE[i]     = 1'b0;
        PIN_PULLUP[i] = opt_eff[i];                         // R4
      end
      // Output pin feeds latch to peripheral input, else the pin
      ALT_IN_VAL[i] = (ALT_IN_EN[i] && dir_eff[i]) ? data_reg[i] : PIN_IN[i]; // R17
    end
  end

  // Two-flop synchroniser then edge compare
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg  <= '0;
    end else if (CLK_EN) begin
      sync1_reg <= PIN_IN;                                  // R24
      sync2_reg <= sync1_reg;                               // R24
      prev_reg  <= sync2_reg;
    end
  end

  // Pin p of port v maps to vector v
  always_comb begin
    for (int i = 0; i < NB; i++) begin
      edge_hit[i] = (edge_reg[i/8] ? (sync2_reg[i] && !prev_reg[i])
                                   : (!sync2_reg[i] && prev_reg[i])) // R10
                    && eien_reg[i] && !dir_eff[i] && !ALT_OUT_EN[i]; // R9 R14
    end
    for (int v = 0; v < NVEC; v++) begin
      vec_event[v] = |edge_hit[v*8 +: 8];                   // R11
    end
  end

  // Edge control write clears requests whose polarity bit changed
  assign edge_clr = (WR && ADDR == gpio_pkg::EDGE_CTRL_ADDR)
                    ? (WDATA[NVEC-1:0] ^ edge_reg[NVEC-1:0]) : '0; // R13

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      pend_reg <= '0;
    end else if (CLK_EN) begin
      // Set wins over fetch clear so no edge is lost
      pend_reg <= (pend_reg & ~VEC_FETCH & ~edge_clr) | vec_event; // R12 R13
    end
  end

  assign EXT_IRQ = pend_reg & {NVEC{!IRQ_MASKED}};          // R14
  // Wake is unmasked by the core mask; the core unmasks on wait or halt
  assign WAKEUP  = |pend_reg;                               // R19

  // Register writes
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      data_reg      <= '0;                                  // R21
      dir_reg       <= '0;
      opt_reg       <= '0;
      eien_reg      <= '0;
      edge_reg      <= gpio_pkg::EDGE_RESET;
      small_pkg_reg <= 1'b0;
    end else if (CLK_EN && WR) begin
      if (port_of(ADDR) < 3'(NPORTS)) begin                 // R23
        case (field_of(ADDR))
          gpio_pkg::DATA_OFS: data_reg[port_of(ADDR)*8 +: 8] <= WDATA; // R3 R21
          gpio_pkg::DIR_OFS:  dir_reg[port_of(ADDR)*8 +: 8]  <= WDATA
                                & ~unbonded[port_of(ADDR)*8 +: 8];     // R22
          gpio_pkg::OPT_OFS:  opt_reg[port_of(ADDR)*8 +: 8]  <= WDATA
                                & ~unbonded[port_of(ADDR)*8 +: 8];     // R22
          default: ;
        endcase
      end else if (ADDR >= gpio_pkg::EIEN_BASE_ADDR
                   && ADDR < gpio_pkg::EIEN_BASE_ADDR + 8'(NPORTS)) begin
        eien_reg[(ADDR - gpio_pkg::EIEN_BASE_ADDR)*8 +: 8] <= WDATA;
      end else if (ADDR == gpio_pkg::EDGE_CTRL_ADDR) begin
        edge_reg <= WDATA;
      end else if (ADDR == gpio_pkg::PKG_CFG_ADDR) begin
        small_pkg_reg <= WDATA[0];
      end
    end
  end

  // Read path, valid in the cycle after the strobe
  always_comb begin
    logic [2:0] p;
    logic [7:0] pin_view;
    p = port_of(ADDR);
    pin_view = '0;
    rd_mux = gpio_pkg::UNMAP_READ;
    if (p < 3'(NPORTS)) begin
      for (int b = 0; b < 8; b++) begin
        if (dir_eff[p*8+b])
          pin_view[b] = data_reg[p*8+b];                    // R5
        else if (ALT_OUT_EN[p*8+b])
          pin_view[b] = ALT_OUT_VAL[p*8+b];                 // R16
        else
          pin_view[b] = sync2_reg[p*8+b];                   // R2
      end
      case (field_of(ADDR))
        gpio_pkg::DATA_OFS: rd_mux = pin_view | unbonded[p*8 +: 8];   // R22
        gpio_pkg::DIR_OFS:  rd_mux = dir_eff[p*8 +: 8];     // R22
        gpio_pkg::OPT_OFS:  rd_mux = opt_reg[p*8 +: 8] & ~unbonded[p*8 +: 8]; // R22
        default:            rd_mux = gpio_pkg::UNMAP_READ;
      endcase
    end else if (ADDR >= gpio_pkg::EIEN_BASE_ADDR
                 && ADDR < gpio_pkg::EIEN_BASE_ADDR + 8'(NPORTS)) begin
      rd_mux = eien_reg[(ADDR - gpio_pkg::EIEN_BASE_ADDR)*8 +: 8];
    end else if (ADDR == gpio_pkg::EDGE_CTRL_ADDR) begin
      rd_mux = edge_reg;
    end else if (ADDR == gpio_pkg::PEND_ADDR) begin
      rd_mux = 8'(pend_reg);
    end else if (ADDR == gpio_pkg::PKG_CFG_ADDR) begin
      rd_mux = {7'h00, small_pkg_reg};
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      rdata_reg <= '0;
    end else if (CLK_EN) begin
      rdata_reg <= RD ? rd_mux : 8'h00;
    end
  end

  assign RDATA = rdata_reg;
endmodule : gpio_ports

`default_nettype wire

// ==== gp_checker.sv ====
// Purpose: Port-level checks of the I/O port block
// Assumes: CLK_EN held high by the bench
// Notes:   Pin-stable guards keep fresh edges, which win over clears, out of the clear checks
`timescale 1ns/1ps
`default_nettype none
module gp_checker #(parameter int NPORTS = 5, parameter int NVEC = 5) (
  // Clock, reset and register port
  input wire logic                CLK, RESET, WR, RD,
  input wire logic [7:0]          ADDR, WDATA, RDATA,
  // Pads and alternate functions
  input wire logic [NPORTS*8-1:0] PIN_IN, PIN_OUT, PIN_OE, PIN_PULLUP, ALT_OUT_EN, ALT_OUT_VAL,
  // Interrupts
  input wire logic                IRQ_MASKED, WAKEUP,
  input wire logic [NVEC-1:0]     VEC_FETCH, EXT_IRQ
);
  logic [NVEC-1:0] edge_reg;
  // Shadow of edge control so a write can be compared with the old setting
  always_ff @(posedge CLK or posedge RESET)
    if (RESET) edge_reg <= '0;
    else if (WR && ADDR == gpio_pkg::EDGE_CTRL_ADDR) edge_reg <= WDATA[NVEC-1:0];
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  a_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00) else $error("read data late");
  a_pull_drive: assert property ((PIN_OE & PIN_PULLUP) == '0) else $error("pull-up on output");
  a_mask_block: assert property (IRQ_MASKED |-> EXT_IRQ == '0) else $error("masked request");
  a_wake_pend: assert property (EXT_IRQ != '0 |-> WAKEUP) else $error("no wakeup");
  a_unmask_show: assert property (!IRQ_MASKED && WAKEUP |-> EXT_IRQ != '0) else $error("no req");
  a_alt_enable: assert property ((ALT_OUT_EN & ~PIN_OE) == '0) else $error("alt not driven");
  a_alt_value: assert property (((PIN_OUT ^ ALT_OUT_VAL) & ALT_OUT_EN) == '0) else $error("alt");
  a_fetch_clear: assert property ($stable(PIN_IN)[*5] ##0 (VEC_FETCH != '0 && !IRQ_MASKED)
    |=> (EXT_IRQ & $past(VEC_FETCH)) == '0) else $error("fetch left request");
  a_edge_clear: assert property ($stable(PIN_IN)[*5] ##0 (WR && ADDR == gpio_pkg::EDGE_CTRL_ADDR)
    |=> (EXT_IRQ & ($past(WDATA[NVEC-1:0]) ^ $past(edge_reg))) == '0) else $error("edge");
endmodule : gp_checker
bind gpio_ports gp_checker #(.NPORTS(NPORTS), .NVEC(NVEC)) gp_checker_i (.CLK(CLK),
  .RESET(RESET), .WR(WR), .RD(RD), .ADDR(ADDR), .WDATA(WDATA), .RDATA(RDATA), .PIN_IN(PIN_IN),
  .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .PIN_PULLUP(PIN_PULLUP), .ALT_OUT_EN(ALT_OUT_EN),
  .ALT_OUT_VAL(ALT_OUT_VAL), .IRQ_MASKED(IRQ_MASKED), .WAKEUP(WAKEUP),
  .VEC_FETCH(VEC_FETCH), .EXT_IRQ(EXT_IRQ));
`default_nettype wire

// ==== gp_pin_model.sv ====
// Purpose: Pads and the world outside them
// Assumes: Bench turns its own drive off where the block drives
// Notes:   A pin nobody drives or pulls shows the inverse of its last driven level
`timescale 1ns/1ps
`default_nettype none
module gp_pin_model #(parameter int W = 40) (
  // Clock and block drive
  input  wire logic         clk,
  input  wire logic [W-1:0] pad_out, pad_oe, pad_pu,
  // Outside drivers
  input  wire logic [W-1:0] ext_val, ext_en,
  output logic      [W-1:0] level
);
  logic [W-1:0] held_reg;
  always_comb
    for (int i = 0; i < W; i++)
      level[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i] : pad_pu[i] | ~held_reg[i];
  always_ff @(posedge clk)
    held_reg <= (level & (pad_oe | ext_en | pad_pu)) | (held_reg & ~(pad_oe | ext_en | pad_pu));
endmodule : gp_pin_model
`default_nettype wire

// ==== tb_top.sv ====
// Purpose: Self-checking bench for the I/O port block
// Assumes: Read data stand one cycle after the read strobe
// Notes:   Expected read data queue up; a negedge monitor compares them
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  logic CLK = 0, RESET = 1, WR = 0, RD = 0, IRQ_MASKED = 1, WAKEUP, rd_pend = 0;
  logic [7:0]  ADDR = '0, WDATA = '0, RDATA, d, mon_exp, lat [5];
  logic [39:0] PIN_IN, PIN_OUT, PIN_OE, PIN_PULLUP, ALT_IN_VAL, ext_val = '0, ext_en = '1;
  logic [39:0] ALT_OUT_EN = '0, ALT_OUT_VAL = '0, ALT_IN_EN = '0;
  logic [4:0]  VEC_FETCH = '0, EXT_IRQ;
  logic [7:0]  exp_q [$];
  int err_total = 0, checks_done = 0, seed = 82327;
  gpio_ports gpio_ports_i (.CLK(CLK), .RESET(RESET), .CLK_EN(1'b1), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
    .PIN_PULLUP(PIN_PULLUP), .ALT_OUT_EN(ALT_OUT_EN), .ALT_OUT_VAL(ALT_OUT_VAL),
    .ALT_IN_EN(ALT_IN_EN), .ALT_IN_VAL(ALT_IN_VAL), .IRQ_MASKED(IRQ_MASKED),
    .VEC_FETCH(VEC_FETCH), .EXT_IRQ(EXT_IRQ), .WAKEUP(WAKEUP));
  gp_pin_model gp_pin_model_i (.clk(CLK), .pad_out(PIN_OUT), .pad_oe(PIN_OE),
    .pad_pu(PIN_PULLUP), .ext_val(ext_val), .ext_en(ext_en), .level(PIN_IN));
  always #2 CLK = ~CLK;
  always @(negedge CLK) begin
    if (rd_pend) begin
      mon_exp = exp_q.pop_front();
      `CHK(RDATA, mon_exp)
    end
    rd_pend = RD;
  end
  function automatic logic [7:0] ra(int p, int o);
    return 8'h26 + 8'(3 * p + o);
  endfunction : ra
  task automatic cyc(int n);
    repeat (n) @(posedge CLK);
  endtask : cyc
  task automatic wr(logic [7:0] a, logic [7:0] v);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
    @(posedge CLK);
  endtask : wr
  task automatic rd(logic [7:0] a, logic [7:0] e);
    exp_q.push_back(e);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
  endtask : rd
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report
  // Samples on the falling edge so the request has settled, then realigns to rising
  task automatic wait_irq(logic [4:0] e);
    int n;
    n = 0;
    @(negedge CLK);
    while (n < 8 && EXT_IRQ !== e) begin
      @(negedge CLK);
      n++;
    end
    `CHK(EXT_IRQ, e)
    if (EXT_IRQ !== e) final_report();
    @(posedge CLK);
  endtask : wait_irq
  initial begin
    cyc(10);
    RESET <= 1'b0;
    ext_val <= {$random(seed), 8'($random(seed))};
    cyc(4);
    for (int p = 0; p < 5; p++) begin
      rd(ra(p, 0), ext_val[8*p+:8]);
      rd(ra(p, 1), 8'h00);
      rd(ra(p, 2), 8'h00);
    end
    rd(8'h3F, 8'h00);
    for (int p = 0; p < 5; p++) begin
      d = 8'($random(seed));
      lat[p] = d;
      wr(ra(p, 0), d);
      rd(ra(p, 0), ext_val[8*p+:8]);
      wr(ra(p, 2), 8'hFF);
      `CHK(PIN_PULLUP[8*p+:8], 8'hFF)
      ext_en[8*p+:8] <= 8'h00;
      wr(ra(p, 1), 8'hFF);
      `CHK({PIN_OE[8*p+:8], PIN_OUT[8*p+:8]}, {8'hFF, d})
      wr(ra(p, 2), 8'h00);
      `CHK({PIN_OE[8*p+:8], PIN_OUT[8*p+:8] & PIN_OE[8*p+:8]}, {~d, 8'h00})
      rd(ra(p, 0), d);
    end
    ALT_IN_EN[31:24] <= 8'hFF;
    cyc(1);
    `CHK(ALT_IN_VAL[31:24], lat[3])
    wr(ra(0, 1), 8'h00);
    ext_val[7:0] <= 8'h00;
    ext_en[7:0] <= 8'hFF;
    cyc(4);
    wr(8'h40, 8'hFF);
    wr(gpio_pkg::EDGE_CTRL_ADDR, 8'h01);
    IRQ_MASKED <= 1'b0;
    ext_val[0] <= 1'b1;
    wait_irq(5'h01);
    rd(gpio_pkg::PEND_ADDR, 8'h01);
    cyc(3);
    VEC_FETCH <= 5'h01;
    @(posedge CLK);
    VEC_FETCH <= 5'h00;
    wait_irq(5'h00);
    ext_val[7:0] <= 8'hFF;
    wait_irq(5'h01);
    IRQ_MASKED <= 1'b1;
    cyc(1);
    `CHK({WAKEUP, EXT_IRQ}, 6'h20)
    IRQ_MASKED <= 1'b0;
    cyc(5);
    wr(gpio_pkg::EDGE_CTRL_ADDR, 8'h00);
    `CHK({WAKEUP, EXT_IRQ}, 6'h00)
    ext_val[3] <= 1'b0;
    wait_irq(5'h01);
    wr(ra(3, 1), 8'h00);
    d = 8'($random(seed));
    ALT_OUT_EN[31:24] <= 8'hFF;
    ALT_OUT_VAL[31:24] <= d;
    cyc(4);
    rd(ra(3, 0), d);
    ALT_OUT_EN <= '0;
    wr(gpio_pkg::PKG_CFG_ADDR, 8'h01);
    wr(ra(1, 1), 8'hFF);
    rd(ra(1, 1), 8'h00);
    rd(ra(1, 0), 8'hFF);
    rd(ra(4, 1), 8'h8F);
    `CHK({PIN_OE[15:8], PIN_PULLUP[15:8]}, 16'h00FF)
    cyc(4);
    final_report();
  end
endmodule : tb_top
`default_nettype wire
